// [twm_pkg.sv]
/*
 Constants, register layout and mode types for the 16-bit timer with
 waveform mode and compare-output control.
 Assumes an APB slave, one clock pclk, active-low async reset presetn.
*/
// Functional notes
// - Synchronous to pclk, timer tick as enable
// - Dual-slope frequency-correct modes update compares at bottom
// - Nonzero compare mode connects waveform to pin
// - Pin driver needs direction bit set
// - Non-PWM: off, toggle, clear, set on match
// - Fast PWM: clear/set on match, opposite at top
// - PWM mode 1: toggle A only if top bit
// - Fast PWM compare equals top: top action only
// - Dual-slope: up-match and down-match opposite actions
// - Low mode bits plus high bits form mode
// - Normal and clear-on-match tops, immediate update
// - Modes 1-3 phase correct fixed tops
// - Modes 5-7,14,15 fast PWM, top update
// - Modes 8,9 update and overflow at bottom
// - Modes 10,11 update top, overflow bottom
// - Dual-slope counts up then down, turns at top after one tick
// - Clock select: stop, prescales, external edges
package twm_pkg;
    localparam logic [11:0] TWM_OFF_CTRL_A = 12'h000;
    localparam logic [11:0] TWM_OFF_CTRL_B = 12'h004;
    localparam logic [11:0] TWM_OFF_COUNT = 12'h008;
    localparam logic [11:0] TWM_OFF_CMP_A = 12'h00C;
    localparam logic [11:0] TWM_OFF_CMP_B = 12'h010;
    localparam logic [11:0] TWM_OFF_CAPTURE = 12'h014;
    localparam logic [11:0] TWM_OFF_IRQ_STATUS = 12'h018;
    localparam logic [11:0] TWM_OFF_IRQ_MASK = 12'h01C;
    localparam logic [11:0] TWM_OFF_DIR = 12'h020;

    localparam logic [7:0] TWM_CTRL_A_MASK = 8'hF3;
    localparam logic [7:0] TWM_CTRL_B_MASK = 8'hDF;
    localparam logic [7:0] TWM_RESET_BYTE = 8'h00;
    localparam logic [15:0] TWM_MAX = 16'hFFFF;
    localparam logic [15:0] TWM_BOTTOM = 16'h0000;
    localparam logic [15:0] TWM_TOP_8 = 16'h00FF;
    localparam logic [15:0] TWM_TOP_9 = 16'h01FF;
    localparam logic [15:0] TWM_TOP_10 = 16'h03FF;
    localparam logic [15:0] TWM_ONE = 16'h0001;
    localparam logic [9:0] TWM_PRE_ONE = 10'h001;
    localparam logic [9:0] TWM_PRE_8 = 10'h007;
    localparam logic [9:0] TWM_PRE_64 = 10'h03F;
    localparam logic [9:0] TWM_PRE_256 = 10'h0FF;
    localparam logic [9:0] TWM_PRE_1024 = 10'h3FF;

    localparam logic [1:0] TWM_COM_OFF = 2'h0;
    localparam logic [1:0] TWM_COM_TOGGLE = 2'h1;
    localparam logic [1:0] TWM_COM_CLEAR = 2'h2;
    localparam logic [1:0] TWM_COM_SET = 2'h3;

    localparam logic [2:0] TWM_CS_STOP = 3'h0;
    localparam logic [2:0] TWM_CS_DIV1 = 3'h1;
    localparam logic [2:0] TWM_CS_DIV8 = 3'h2;
    localparam logic [2:0] TWM_CS_DIV64 = 3'h3;
    localparam logic [2:0] TWM_CS_DIV256 = 3'h4;
    localparam logic [2:0] TWM_CS_DIV1024 = 3'h5;
    localparam logic [2:0] TWM_CS_EXT_FALL = 3'h6;
    localparam logic [2:0] TWM_CS_EXT_RISE = 3'h7;

    localparam int TWM_IRQ_OVF = 0;
    localparam int TWM_IRQ_CMPA = 1;
    localparam int TWM_IRQ_CMPB = 2;
    localparam int TWM_IRQ_CAP = 3;

    typedef enum logic [3:0]
    {
        TWM_SEQ_NORMAL = 4'b0001,
        TWM_SEQ_CTC = 4'b0010,
        TWM_SEQ_FAST = 4'b0100,
        TWM_SEQ_DUAL = 4'b1000
    } twm_seq_e;

    typedef enum logic [2:0]
    {
        TWM_TOP_FIXED = 3'b001,
        TWM_TOP_CMPA = 3'b010,
        TWM_TOP_CAPT = 3'b100
    } twm_topsrc_e;

    typedef struct packed
    {
        twm_seq_e seq;
        twm_topsrc_e topsrc;
        logic [15:0] fixed_top;
        logic upd_bottom;
        logic upd_immediate;
    } twm_mode_s;

    typedef struct packed
    {
        logic [1:0] com_a;
        logic [1:0] com_b;
        logic [1:0] rsvd;
        logic [1:0] wave_mode_low;
    } twm_ctrl_a_s;

    typedef struct packed
    {
        logic noise_cancel;
        logic edge_rise;
        logic rsvd;
        logic [1:0] wave_mode_high;
        logic [2:0] clock_select;
    } twm_ctrl_b_s;
endpackage

// [twm_timer.sv]
/*
 Timer core: prescaler, 16-bit counter, mode decode, two compare
 channels with waveform outputs, APB registers and interrupt.
 Assumes an APB master on pclk and raw pins for the external clock
 and capture input, synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module twm_timer
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_clk_pin,
    input wire logic capture_pin,
    output logic wave_out_a,
    output logic wave_out_a_oe,
    output logic wave_out_b,
    output logic wave_out_b_oe,
    output logic irq
);
    import twm_pkg::*;

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    function automatic twm_mode_s decode_mode(input logic [3:0] m);
        twm_mode_s d;
        d = '{TWM_SEQ_NORMAL, TWM_TOP_FIXED, TWM_MAX, 1'b0, 1'b1};
        unique case (m)
            4'h1: d = '{TWM_SEQ_DUAL, TWM_TOP_FIXED, TWM_TOP_8, 1'b0, 1'b0};
            4'h2: d = '{TWM_SEQ_DUAL, TWM_TOP_FIXED, TWM_TOP_9, 1'b0, 1'b0};
            4'h3: d = '{TWM_SEQ_DUAL, TWM_TOP_FIXED, TWM_TOP_10, 1'b0, 1'b0};
            4'h4: d = '{TWM_SEQ_CTC, TWM_TOP_CMPA, TWM_MAX, 1'b0, 1'b1};
            4'h5: d = '{TWM_SEQ_FAST, TWM_TOP_FIXED, TWM_TOP_8, 1'b0, 1'b0};
            4'h6: d = '{TWM_SEQ_FAST, TWM_TOP_FIXED, TWM_TOP_9, 1'b0, 1'b0};
            4'h7: d = '{TWM_SEQ_FAST, TWM_TOP_FIXED, TWM_TOP_10, 1'b0, 1'b0};
            4'h8: d = '{TWM_SEQ_DUAL, TWM_TOP_CAPT, TWM_MAX, 1'b1, 1'b0};
            4'h9: d = '{TWM_SEQ_DUAL, TWM_TOP_CMPA, TWM_MAX, 1'b1, 1'b0};
            4'hA: d = '{TWM_SEQ_DUAL, TWM_TOP_CAPT, TWM_MAX, 1'b0, 1'b0};
            4'hB: d = '{TWM_SEQ_DUAL, TWM_TOP_CMPA, TWM_MAX, 1'b0, 1'b0};
            4'hC: d = '{TWM_SEQ_CTC, TWM_TOP_CAPT, TWM_MAX, 1'b0, 1'b1};
            4'hE: d = '{TWM_SEQ_FAST, TWM_TOP_CAPT, TWM_MAX, 1'b0, 1'b0};
            4'hF: d = '{TWM_SEQ_FAST, TWM_TOP_CMPA, TWM_MAX, 1'b0, 1'b0};
            // Mode 13 is reserved; it falls back to normal counting
            default: d = '{TWM_SEQ_NORMAL, TWM_TOP_FIXED, TWM_MAX, 1'b0, 1'b1};
        endcase
        return d;
    endfunction

    // Applies one compare-output action to the current level
    function automatic logic com_act(input logic [1:0] act, input logic cur);
        logic r;
        r = cur;
        unique case (act)
            TWM_COM_OFF: r = cur;
            TWM_COM_TOGGLE: r = ~cur;
            TWM_COM_CLEAR: r = 1'b0;
            TWM_COM_SET: r = 1'b1;
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    twm_ctrl_a_s ctrl_a, next_ctrl_a;
    twm_ctrl_b_s ctrl_b, next_ctrl_b;
    logic [15:0] count_value, next_count_value;
    logic count_down, next_count_down;
    logic [15:0] cmp_value_a, next_cmp_value_a;
    logic [15:0] cmp_value_b, next_cmp_value_b;
    logic [15:0] cmp_buf_a, next_cmp_buf_a;
    logic [15:0] cmp_buf_b, next_cmp_buf_b;
    logic [15:0] capture_value, next_capture_value;
    logic [3:0] irq_status, next_irq_status;
    logic [3:0] irq_mask, next_irq_mask;
    logic [1:0] pin_dir, next_pin_dir;
    logic [9:0] prescale, next_prescale;
    logic wave_a, next_wave_a;
    logic wave_b, next_wave_b;
    logic block_match, next_block_match;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_irq;
    logic ext_s1, ext_s2, ext_s3;
    logic cap_s1, cap_s2, cap_s3;

    logic [3:0] wave_mode;
    twm_mode_s md;
    logic [15:0] top;
    logic tick;
    logic at_top;
    logic at_bottom;
    logic match_a;
    logic match_b;
    logic upd_now;
    logic wr;
    logic rd;
    logic [3:0] ev;
    logic cap_edge;

    assign wave_mode = {ctrl_b.wave_mode_high, ctrl_a.wave_mode_low};
    assign md = decode_mode(wave_mode);
    assign wr = psel && penable && pwrite && !pready;
    assign rd = psel && penable && !pwrite && !pready;

    // ----------------------------------------------------------------
    // Top, timer tick and events
    // ----------------------------------------------------------------
    always_comb
    begin
        unique case (md.topsrc)
            TWM_TOP_FIXED: top = md.fixed_top;
            TWM_TOP_CMPA: top = cmp_value_a;
            TWM_TOP_CAPT: top = capture_value;
        endcase
        // Tick is a one-cycle enable; the counter never runs on its own clock
        unique case (ctrl_b.clock_select)
            TWM_CS_STOP: tick = 1'b0;
            TWM_CS_DIV1: tick = 1'b1;
            TWM_CS_DIV8: tick = (prescale & TWM_PRE_8) == TWM_PRE_8;
            TWM_CS_DIV64: tick = (prescale & TWM_PRE_64) == TWM_PRE_64;
            TWM_CS_DIV256: tick = (prescale & TWM_PRE_256) == TWM_PRE_256;
            TWM_CS_DIV1024: tick = prescale == TWM_PRE_1024;
            TWM_CS_EXT_FALL: tick = ext_s3 && !ext_s2;
            TWM_CS_EXT_RISE: tick = !ext_s3 && ext_s2;
        endcase
        at_top = count_value == top;
        at_bottom = count_value == TWM_BOTTOM;
        match_a = tick && !block_match && count_value == cmp_value_a;
        match_b = tick && !block_match && count_value == cmp_value_b;
        cap_edge = ctrl_b.edge_rise ? (!cap_s3 && cap_s2) : (cap_s3 && !cap_s2);
        upd_now = 1'b0;
        ev = 4'h0;
        ev[TWM_IRQ_CMPA] = match_a;
        ev[TWM_IRQ_CMPB] = match_b;
        ev[TWM_IRQ_CAP] = cap_edge && md.topsrc != TWM_TOP_CAPT;
        unique case (md.seq)
            TWM_SEQ_NORMAL, TWM_SEQ_CTC:
            begin
                ev[TWM_IRQ_OVF] = tick && count_value == TWM_MAX;
            end
            TWM_SEQ_FAST:
            begin
                ev[TWM_IRQ_OVF] = tick && at_top;
                upd_now = tick && at_top;
            end
            TWM_SEQ_DUAL:
            begin
                ev[TWM_IRQ_OVF] = tick && at_bottom && count_down;
                upd_now = tick && (md.upd_bottom ? (at_bottom && count_down)
                                                 : (at_top && !count_down));
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Counter and waveform
    // ----------------------------------------------------------------
    always_comb
    begin
        next_prescale = ctrl_b.clock_select == TWM_CS_STOP ? TWM_PRE_ONE - TWM_PRE_ONE
                                                         : prescale + TWM_PRE_ONE;
        next_count_value = count_value;
        next_count_down = count_down;
        next_cmp_buf_a = cmp_buf_a;
        next_cmp_buf_b = cmp_buf_b;
        next_cmp_value_a = cmp_value_a;
        next_cmp_value_b = cmp_value_b;
        next_capture_value = capture_value;
        next_wave_a = wave_a;
        next_wave_b = wave_b;
        next_block_match = block_match && !tick;
        if (tick)
        begin
            unique case (md.seq)
                TWM_SEQ_NORMAL: next_count_value = count_value + TWM_ONE;
                TWM_SEQ_CTC, TWM_SEQ_FAST:
                    next_count_value = at_top ? TWM_BOTTOM : count_value + TWM_ONE;
                TWM_SEQ_DUAL:
                begin
                    // Top stands for one tick, then the count turns down
                    if (!count_down && at_top)
                    begin
                        next_count_down = 1'b1;
                        next_count_value = count_value - TWM_ONE;
                    end
                    else if (count_down && at_bottom)
                    begin
                        next_count_down = 1'b0;
                        next_count_value = count_value + TWM_ONE;
                    end
                    else if (count_down)
                        next_count_value = count_value - TWM_ONE;
                    else
                        next_count_value = count_value + TWM_ONE;
                end
            endcase
        end
        if (upd_now)
        begin
            next_cmp_value_a = cmp_buf_a;
            next_cmp_value_b = cmp_buf_b;
        end
        if (cap_edge && md.topsrc != TWM_TOP_CAPT)
            next_capture_value = count_value;
        unique case (md.seq)
            TWM_SEQ_NORMAL, TWM_SEQ_CTC:
            begin
                if (match_a) next_wave_a = com_act(ctrl_a.com_a, wave_a);
                if (match_b) next_wave_b = com_act(ctrl_a.com_b, wave_b);
            end
            TWM_SEQ_FAST:
            begin
                if (ctrl_a.com_a == TWM_COM_TOGGLE)
                begin
                    if (match_a && wave_mode[3]) next_wave_a = ~wave_a;
                end
                else if (ctrl_a.com_a[1] && tick && at_top)
                    next_wave_a = ~ctrl_a.com_a[0];
                else if (ctrl_a.com_a[1] && match_a)
                    next_wave_a = ctrl_a.com_a[0];
                if (ctrl_a.com_b[1] && tick && at_top)
                    next_wave_b = ~ctrl_a.com_b[0];
                else if (ctrl_a.com_b[1] && match_b)
                    next_wave_b = ctrl_a.com_b[0];
            end
            TWM_SEQ_DUAL:
            begin
                if (ctrl_a.com_a == TWM_COM_TOGGLE)
                begin
                    if (match_a && wave_mode[3]) next_wave_a = ~wave_a;
                end
                else if (ctrl_a.com_a[1] && match_a)
                    next_wave_a = ctrl_a.com_a[0] ^ count_down;
                if (ctrl_a.com_b[1] && match_b)
                    next_wave_b = ctrl_a.com_b[0] ^ count_down;
            end
        endcase
        if (wr && paddr == TWM_OFF_COUNT)
        begin
            next_count_value = pwdata[15:0];
            next_block_match = 1'b1;
        end
        if (wr && paddr == TWM_OFF_CAPTURE)
            next_capture_value = pwdata[15:0];
        if (wr && paddr == TWM_OFF_CMP_A)
        begin
            next_cmp_buf_a = pwdata[15:0];
            if (md.upd_immediate) next_cmp_value_a = pwdata[15:0];
        end
        if (wr && paddr == TWM_OFF_CMP_B)
        begin
            next_cmp_buf_b = pwdata[15:0];
            if (md.upd_immediate) next_cmp_value_b = pwdata[15:0];
        end
    end

    // ----------------------------------------------------------------
    // Registers and APB
    // ----------------------------------------------------------------
    always_comb
    begin
        next_ctrl_a = ctrl_a;
        next_ctrl_b = ctrl_b;
        next_irq_mask = irq_mask;
        next_pin_dir = pin_dir;
        // Set wins over a simultaneous write-one clear
        next_irq_status = irq_status | ev;
        next_pready = psel && penable && !pready;
        next_pslverr = 1'b0;
        next_prdata = 32'h0000_0000;
        if (wr)
        begin
            unique case (paddr)
                TWM_OFF_CTRL_A: next_ctrl_a = pwdata[7:0] & TWM_CTRL_A_MASK;
                TWM_OFF_CTRL_B: next_ctrl_b = pwdata[7:0] & TWM_CTRL_B_MASK;
                TWM_OFF_IRQ_STATUS: next_irq_status = (irq_status & ~pwdata[3:0]) | ev;
                TWM_OFF_IRQ_MASK: next_irq_mask = pwdata[3:0];
                TWM_OFF_DIR: next_pin_dir = pwdata[1:0];
                TWM_OFF_COUNT, TWM_OFF_CMP_A, TWM_OFF_CMP_B, TWM_OFF_CAPTURE: ;
                default: next_pslverr = 1'b1;
            endcase
        end
        if (rd)
        begin
            unique case (paddr)
                TWM_OFF_CTRL_A: next_prdata[7:0] = ctrl_a;
                TWM_OFF_CTRL_B: next_prdata[7:0] = ctrl_b;
                TWM_OFF_COUNT: next_prdata[15:0] = count_value;
                TWM_OFF_CMP_A: next_prdata[15:0] = cmp_buf_a;
                TWM_OFF_CMP_B: next_prdata[15:0] = cmp_buf_b;
                TWM_OFF_CAPTURE: next_prdata[15:0] = capture_value;
                TWM_OFF_IRQ_STATUS: next_prdata[3:0] = irq_status;
                TWM_OFF_IRQ_MASK: next_prdata[3:0] = irq_mask;
                TWM_OFF_DIR: next_prdata[1:0] = pin_dir;
                default: next_pslverr = 1'b1;
            endcase
        end
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_a <= TWM_RESET_BYTE;
            ctrl_b <= TWM_RESET_BYTE;
            count_value <= TWM_BOTTOM;
            count_down <= 1'b0;
            cmp_value_a <= TWM_BOTTOM;
            cmp_value_b <= TWM_BOTTOM;
            cmp_buf_a <= TWM_BOTTOM;
            cmp_buf_b <= TWM_BOTTOM;
            capture_value <= TWM_BOTTOM;
            irq_status <= 4'h0;
            irq_mask <= 4'h0;
            pin_dir <= 2'h0;
            prescale <= 10'h000;
            wave_a <= 1'b0;
            wave_b <= 1'b0;
            block_match <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
            wave_out_a <= 1'b0;
            wave_out_a_oe <= 1'b0;
            wave_out_b <= 1'b0;
            wave_out_b_oe <= 1'b0;
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
            cap_s1 <= 1'b0;
            cap_s2 <= 1'b0;
            cap_s3 <= 1'b0;
        end
        else if (clk_en)
        begin
            ctrl_a <= next_ctrl_a;
            ctrl_b <= next_ctrl_b;
            count_value <= next_count_value;
            count_down <= next_count_down;
            cmp_value_a <= next_cmp_value_a;
            cmp_value_b <= next_cmp_value_b;
            cmp_buf_a <= next_cmp_buf_a;
            cmp_buf_b <= next_cmp_buf_b;
            capture_value <= next_capture_value;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            pin_dir <= next_pin_dir;
            prescale <= next_prescale;
            wave_a <= next_wave_a;
            wave_b <= next_wave_b;
            block_match <= next_block_match;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            irq <= next_irq;
            // Pin shows waveform only when connected and direction is out
            wave_out_a <= next_wave_a;
            wave_out_a_oe <= (next_ctrl_a.com_a != TWM_COM_OFF) && next_pin_dir[0];
            wave_out_b <= next_wave_b;
            wave_out_b_oe <= (next_ctrl_a.com_b != TWM_COM_OFF) && next_pin_dir[1];
            ext_s1 <= ext_clk_pin;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            cap_s1 <= capture_pin;
            cap_s2 <= cap_s1;
            cap_s3 <= cap_s2;
        end
    end
endmodule // twm_timer
`default_nettype wire

// [twm_timer_assertions.sv]
/*
 Port checker for twm_timer.
 Assumes binding from the testbench top; shadows a few registers.
*/
`timescale 1ns/1ps
`default_nettype none
module twm_timer_assertions
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wave_out_a,
    input wire logic wave_out_a_oe,
    input wire logic wave_out_b,
    input wire logic wave_out_b_oe,
    input wire logic irq
);
    // ----------------------------------------
    // Shadow registers
    // ----------------------------------------
    logic [7:0] sh_a;
    logic [2:0] sh_cs;
    logic [3:0] sh_m;
    logic [1:0] sh_d;
    logic take;
    assign take = psel && penable && clk_en && !pready;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sh_a <= 8'h00;
            sh_cs <= 3'h0;
            sh_m <= 4'h0;
            sh_d <= 2'h0;
        end
        else if (take && pwrite)
        begin
            if (paddr == 12'h000)
                sh_a <= pwdata[7:0];
            if (paddr == 12'h004)
                sh_cs <= pwdata[2:0];
            if (paddr == 12'h01C)
                sh_m <= pwdata[3:0];
            if (paddr == 12'h020)
                sh_d <= pwdata[1:0];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_OE_A: assert property (wave_out_a_oe == (|sh_a[7:6] && sh_d[0]))
        else $error("oe a wrong");
    AST_OE_B: assert property (wave_out_b_oe == (|sh_a[5:4] && sh_d[1]))
        else $error("oe b wrong");
    AST_RSVD: assert property (take && !pwrite && paddr == 12'h000 ##1 clk_en |-> pready && prdata[3:2] == 2'h0)
        else $error("reserved bits not zero");
    AST_FREEZE: assert property (!clk_en |=> $stable(wave_out_a) && $stable(wave_out_b) && $stable(irq))
        else $error("moved without enable");
    AST_STOP: assert property ((sh_cs == 3'h0 && !psel) [*5] |-> $stable(wave_out_a) && $stable(irq))
        else $error("moved while stopped");
    AST_MASK: assert property (sh_m == 4'h0 |-> !irq)
        else $error("irq while masked");
    AST_ERR: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("ready too long");
    AST_UNMAP: assert property (take && paddr > 12'h020 ##1 clk_en |-> pslverr && prdata == 32'h0)
        else $error("unmapped not refused");
endmodule // twm_timer_assertions
`default_nettype wire

// [twm_timer_tb.sv]
/*
 Self-checking bench for twm_timer.
 Assumes the checker file is compiled first; pins tied idle.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) \
        begin \
            err_total++; \
            $display("[ERR] %s exp %0h got %0h", nm, e, g); \
        end \
    end
module twm_timer_tb;
    import twm_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic ext_clk_pin = 1'b0;
    logic capture_pin = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, se, irq;
    logic wave_out_a, wave_out_a_oe, wave_out_b, wave_out_b_oe;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    twm_timer dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_clk_pin,
        .capture_pin, .wave_out_a, .wave_out_a_oe, .wave_out_b,
        .wave_out_b_oe, .irq);
    always #12.5 pclk = ~pclk;
    // ----------------------------------------
    // Bus and helpers
    // ----------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        se = pslverr;
        if (n >= 50)
            err_total++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic setup(input logic [7:0] ca, cb, input logic [15:0] m);
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b1, 12'h018, 32'hF);
        apb(1'b1, 12'h00C, {16'h0, m});
        apb(1'b1, 12'h010, {16'h0, m});
        apb(1'b1, 12'h000, {24'h0, ca});
        apb(1'b1, 12'h004, {24'h0, cb});
    endtask
    // Waits for a settled period first; count windows keep clear of edges
    task automatic probe(input logic [15:0] top, input logic dual, pw);
        logic [15:0] prev;
        logic down;
        prev = 16'h0;
        down = 1'b0;
        repeat (600) @(posedge pclk);
        repeat (150)
        begin
            apb(1'b0, 12'h008, 32'h0);
            `CHK("count", 1'b1, rd[15:0] <= top)
            if (rd[15:0] < prev && prev - rd[15:0] < 16'h0008)
                down = 1'b1;
            prev = rd[15:0];
            if (pw && rd[15:0] inside {[16'h0048:16'h0070]})
                `CHK("pwm above", 2'h1, {wave_out_a, wave_out_b})
            if (pw && rd[15:0] inside {[16'h0008:16'h0038]})
                `CHK("pwm below", 2'h2, {wave_out_a, wave_out_b})
        end
        if (pw)
            `CHK("slope", dual, down)
    endtask
    task automatic ovf(input string nm);
        apb(1'b0, 12'h018, 32'h0);
        `CHK(nm, 1'b1, rd[0])
    endtask
    task automatic final_report();
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        apb(1'b0, 12'h000, 32'h0);
        `CHK("ctrl_a reset", 32'h0, rd)
        apb(1'b1, 12'h000, 32'hFF);
        apb(1'b0, 12'h000, 32'h0);
        `CHK("ctrl_a", 32'hF3, rd)
        apb(1'b1, 12'h004, 32'hFF);
        apb(1'b0, 12'h004, 32'h0);
        `CHK("ctrl_b", 32'hDF, rd)
        apb(1'b0, 12'h024, 32'h0);
        `CHK("unmapped", 33'h100000000, {se, rd})
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, 12'h000, {24'h0, i[1:0], i[1:0], 4'h0});
            apb(1'b1, 12'h020, {30'h0, i[2], i[2]});
            `CHK("oe a", i[1:0] != 2'h0 && i[2], wave_out_a_oe)
            `CHK("oe b", i[1:0] != 2'h0 && i[2], wave_out_b_oe)
        end
    endtask
    task automatic t_wave();
        logic [7:0] ca [3] = '{8'hA0, 8'h70, 8'h60};
        int n;
        logic v;
        setup(8'h41, 8'h09, 16'h0040);
        repeat (600)
        begin
            @(posedge pclk);
            `CHK("pwm toggle off", 1'b0, wave_out_a)
        end
        setup(8'h43, 8'h19, 16'h0040);
        n = 0;
        repeat (650)
        begin
            v = wave_out_a;
            @(posedge pclk);
            n += int'(wave_out_a != v);
        end
        `CHK("toggles", 1'b1, n >= 9 && n <= 11)
        for (int i = 0; i < 3; i++)
        begin
            setup(ca[i], 8'h01, 16'h0005);
            repeat (20) @(posedge pclk);
            `CHK("non pwm", {i == 1, i == 1}, {wave_out_a, wave_out_b})
        end
        setup(8'hC1, 8'h19, 16'h0005);
        repeat (20) @(posedge pclk);
        `CHK("mode 13", 1'b1, wave_out_a)
        setup(8'h00, 8'h09, 16'h0006);
        probe(16'h0006, 1'b0, 1'b0);
    endtask
    task automatic t_pwm();
        logic [7:0] c;
        int n;
        setup(8'hB1, 8'h09, 16'h0040);
        probe(16'h00FF, 1'b0, 1'b1);
        ovf("ovf fast");
        apb(1'b0, 12'h008, 32'h0);
        c = rd[7:0];
        clk_en <= 1'b0;
        repeat (20) @(posedge pclk);
        clk_en <= 1'b1;
        apb(1'b0, 12'h008, 32'h0);
        `CHK("frozen", 1'b1, 8'(rd[7:0] - c) < 8'h0C)
        apb(1'b1, 12'h01C, 32'h1);
        n = 0;
        while (irq !== 1'b1 && n < 300)
        begin
            @(posedge pclk);
            n++;
        end
        `CHK("irq raised", 1'b1, irq)
        apb(1'b1, 12'h01C, 32'h0);
        `CHK("irq masked", 1'b0, irq)
        setup(8'h81, 8'h09, 16'h00FF);
        repeat (600) @(posedge pclk);
        repeat (600)
        begin
            @(posedge pclk);
            `CHK("top match", 1'b1, wave_out_a)
        end
        setup(8'hB1, 8'h01, 16'h0040);
        probe(16'h00FF, 1'b1, 1'b1);
        ovf("ovf dual");
        apb(1'b1, 12'h014, 32'h80);
        setup(8'hB0, 8'h11, 16'h0040);
        probe(16'h0080, 1'b1, 1'b1);
        ovf("ovf freq");
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h018, 32'hF);
        apb(1'b0, 12'h018, 32'h0);
        `CHK("status cleared", 32'h0, rd)
        repeat (10) @(posedge pclk);
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_total++;
            final_report();
        end
    end
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_wave();
        t_pwm();
        final_report();
    end
endmodule // twm_timer_tb
bind twm_timer twm_timer_assertions u_chk (.pclk, .presetn, .clk_en,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .wave_out_a, .wave_out_a_oe, .wave_out_b, .wave_out_b_oe,
    .irq);
`default_nettype wire
